// File: bench/coarse_seek_velocity_control_test.sv
// Testbench for csv_coarse_seek with the detector model.
// Assumes a 20 MHz clock and a shortened seek timeout.
`timescale 1ns/10ps
`default_nettype none
module coarse_seek_velocity_control_test;
    import csv_pkg::*;
    typedef struct packed {
        logic [15:0] cur, dst;
        logic home;
        logic [15:0] t;
        logic slope;
        logic [1:0] fill;
        logic [7:0] code;
    } csv_row_s;
    localparam int TOUT = 4000;
    logic clk = 1'b0, rstn = 1'b0, speedCheckStart = 1'b0, fineHold = 1'b0;
    logic forward = 1'b0, go = 1'b0, stray = 1'b0, old;
    logic posPeak, posPeakPlus, posPeakMinus, zeroCross, halfTrack;
    csv_req_s req = '0;
    logic [15:0] speedCount, tracksToGo;
    logic onTrack, seekFault, integClamp, cylPulse, posSlope;
    logic [7:0] dacCode;
    logic [1:0] fillSel;
    csv_mode_e mode;
    csv_vel_s velCtl;
    int mismatches = 0, cmp_count = 0, pulses = 0, i;
    csv_row_s rows [3] = '{'{16'h0005, 16'h0008, 1'b0, 16'h0003, 1'b1, 2'h3, 8'h04},
        '{16'h0014, 16'h000e, 1'b0, 16'h0006, 1'b0, 2'h2, 8'h08},
        '{16'h000c, 16'h0000, 1'b1, 16'h000c, 1'b0, 2'h1, 8'h0c}};
    always #25 clk = ~clk;
    always @(posedge cylPulse) pulses++;
    csv_coarse_seek #(.TIMEOUT_CYC(TOUT)) uut (.clk(clk), .rstn(rstn), .req(req),
        .speedCheckStart(speedCheckStart), .speedCount(speedCount), .tracksToGo(tracksToGo),
        .onTrack(onTrack), .seekFault(seekFault), .mode(mode), .posPeak(posPeak),
        .posPeakPlus(posPeakPlus), .posPeakMinus(posPeakMinus), .zeroCross(zeroCross),
        .halfTrack(halfTrack), .fineHold(fineHold), .forward(forward), .dacCode(dacCode),
        .fillSel(fillSel), .integClamp(integClamp), .cylPulse(cylPulse),
        .posSlope(posSlope), .velCtl(velCtl));
    csv_servo_model model (.clk(clk), .rstn(rstn), .go(go), .stray(stray), .posPeak(posPeak),
        .posPeakPlus(posPeakPlus), .posPeakMinus(posPeakMinus), .zeroCross(zeroCross),
        .halfTrack(halfTrack));
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // Bounded wait; a hang ends the run
    task automatic waitMode(input csv_mode_e m, input int lim);
        for (i = 0; i < lim && mode !== m; i++) @(negedge clk);
        chk("mode", m, mode);
        if (mode !== m) complete_run();
    endtask
    task automatic startSeek(input csv_row_s r);
        @(posedge clk);
        req.curCyl <= r.cur;
        req.dstCyl <= r.dst;
        req.seek <= !r.home;
        req.home <= r.home;
        waitMode(CSV_COARSE, 5);
        @(posedge clk);
        req.seek <= 1'b0;
        req.home <= 1'b0;
        repeat (2) @(negedge clk);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        for (int r = 0; r < 3; r++) begin
            startSeek(rows[r]);
            chk("tracksToGo", rows[r].t, tracksToGo);
            chk("posSlope", rows[r].slope, posSlope);
            chk("fillSel", rows[r].fill, fillSel);
            chk("dacCode", rows[r].code, dacCode);
            pulses = 0;
            @(posedge clk) go <= 1'b1;
            waitMode(CSV_SETTLE, TOUT);
            @(posedge clk) go <= 1'b0;
            @(negedge clk);
            chk("crossings", rows[r].t, pulses);
            chk("onTrack", 1, onTrack);
            chk("dacEnd", 0, dacCode);
            chk("fillEnd", 3, fillSel);
            $display("Row %0d done", r);
        end
        // Refused restart, unarmed trigger, preset capture, timeout
        startSeek('{16'h0000, 16'h0014, 1'b0, 16'h0014, 1'b1, 2'h0, 8'h44});
        chk("fillSel", 0, fillSel);
        chk("dacCode", 8'h44, dacCode);
        pulses = 0;
        @(posedge clk);
        req.dstCyl <= 16'h0040;
        req.seek <= 1'b1;
        stray <= 1'b1;
        req.preset <= 1'b1;
        fineHold <= 1'b1;
        repeat (6) @(posedge clk);
        req.seek <= 1'b0;
        stray <= 1'b0;
        repeat (100) @(negedge clk);
        chk("tracksToGo", 20, tracksToGo);
        chk("pulses", 0, pulses);
        chk("regionA", 1, velCtl.regionA);
        old = velCtl.invertIn;
        @(posedge clk) forward <= 1'b1;
        repeat (5) @(negedge clk);
        chk("invertIn", !old, velCtl.invertIn);
        for (i = 0; i < TOUT + 100 && mode === CSV_COARSE; i++) @(negedge clk);
        chk("leftCoarse", 1, mode !== CSV_COARSE);
        chk("seekFault", 1, seekFault);
        $display("Timeout test done");
        // Strobes 100 cycles apart; the run count restarts at zero on a strobe
        @(posedge clk) speedCheckStart <= 1'b1;
        @(posedge clk) speedCheckStart <= 1'b0;
        repeat (99) @(posedge clk);
        speedCheckStart <= 1'b1;
        @(posedge clk) speedCheckStart <= 1'b0;
        repeat (2) @(negedge clk);
        chk("speedCount", 99, speedCount);
        @(posedge clk) rstn <= 1'b0;
        @(negedge clk);
        chk("modeReset", CSV_IDLE, mode);
        chk("faultReset", 0, seekFault);
        chk("tracksReset", 0, tracksToGo);
        $display("Speed and reset test done");
        complete_run();
    end
endmodule
bind csv_coarse_seek csv_chk #(.PULSE_CYC(PULSE_CYC)) chk (.*);
`default_nettype wire

// File: bench/csv_coarse_seek_assertions.sv
// Checker for the coarse seek velocity control block.
// Assumes a bind to csv_coarse_seek with its port names.
`timescale 1ns/10ps
`default_nettype none
module csv_chk
    import csv_pkg::*;
#(parameter int PULSE_CYC = 80) (
    // Clock, reset, inputs
    input wire logic                 clk,
    input wire logic                 rstn,
    input wire csv_pkg::csv_req_s    req,
    input wire logic                 halfTrack,
    input wire logic                 posPeakPlus,
    input wire logic                 posPeakMinus,
    // Outputs watched
    input wire csv_pkg::csv_mode_e   mode,
    input wire logic [15:0]          tracksToGo,
    input wire logic [7:0]           dacCode,
    input wire logic [1:0]           fillSel,
    input wire logic                 integClamp,
    input wire logic                 cylPulse,
    input wire logic                 onTrack,
    input wire csv_pkg::csv_vel_s    velCtl
);
    logic [7:0]  pLen;
    logic [15:0] tHeld;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) pLen <= 8'h00;
        else pLen <= cylPulse ? pLen + 8'h01 : 8'h00;
    end
    // Count seen during the pulse, before it drops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) tHeld <= 16'h0000;
        else if (cylPulse) tHeld <= tracksToGo;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence sHand;
        mode == CSV_COARSE && tracksToGo == 16'h0000 && halfTrack;
    endsequence
    AST_PULSE_WIDTH: assert property (!cylPulse && pLen != 8'h00 |-> pLen == PULSE_CYC)
        else $error("cylinder pulse width wrong");
    AST_DECREMENT: assert property ($fell(cylPulse) && mode == CSV_COARSE
        |-> ##[0:2] tracksToGo == tHeld - 16'h0001) else $error("count not decremented");
    AST_CODE_HOLD: assert property ($changed(dacCode) && mode == CSV_COARSE
        |-> $past(cylPulse, 3) || $past(mode, 2) != CSV_COARSE) else $error("code moved");
    AST_FILL_MASK: assert property (mode == CSV_COARSE && $past(mode, 2) == CSV_COARSE
        && $past(tracksToGo) < FILL_LIMIT |-> dacCode[7:6] == 2'b00) else $error("top bits");
    AST_FILL_OFF: assert property (mode == CSV_COARSE && $past(mode, 2) == CSV_COARSE
        && $past(tracksToGo) >= FILL_LIMIT |-> fillSel == 2'b00) else $error("fill early");
    AST_CLAMP: assert property (cylPulse && $past(cylPulse) && mode == CSV_COARSE
        && tracksToGo < CLAMP_LIMIT |-> integClamp) else $error("clamp missing");
    AST_SETTLE: assert property (sHand |-> ##[1:4] mode == CSV_SETTLE)
        else $error("no hand-over");
    AST_ON_TRACK: assert property (mode == CSV_SETTLE && $past(mode) == CSV_COARSE
        |-> onTrack) else $error("on-track not set");
    AST_START: assert property (mode != CSV_COARSE && (req.seek || req.home)
        |-> ##[1:3] mode == CSV_COARSE) else $error("seek not started");
    AST_PEAK: assert property (((posPeakPlus || posPeakMinus) && mode == CSV_COARSE) [*4]
        |-> !velCtl.regionA && !velCtl.regionB && velCtl.integrate) else $error("peak ctl");
    AST_LINEAR: assert property ((!posPeakPlus && !posPeakMinus && mode == CSV_COARSE) [*4]
        |-> velCtl.amplify && velCtl.regionA != velCtl.regionB) else $error("linear ctl");
endmodule
`default_nettype wire

// File: bench/csv_servo_model.sv
// Servo detector model: peaks, zero crossings, half-track level.
// Assumes go is held high only while a seek should move.
`timescale 1ns/10ps
`default_nettype none
module csv_servo_model (
    input wire logic  clk,
    input wire logic  rstn,
    input wire logic  go,
    input wire logic  stray,
    output logic      posPeak,
    output logic      posPeakPlus,
    output logic      posPeakMinus,
    output logic      zeroCross,
    output logic      halfTrack
);
    logic [7:0] ph;
    logic       neg;
    // One track per 200 cycles; peak polarity alternates
    // Half-track level comes after the crossing pulse has ended
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ph <= 8'h00;
            neg <= 1'b0;
        end else if (go) begin
            ph <= (ph == 8'hc7) ? 8'h00 : ph + 8'h01;
            if (ph == 8'hc7) neg <= ~neg;
        end else ph <= 8'h00;
    end
    always_comb begin
        posPeak = go && ph < 8'h14;
        posPeakPlus = posPeak && !neg;
        posPeakMinus = posPeak && neg;
        zeroCross = (go && ph >= 8'h64 && ph < 8'h78) || stray;
        halfTrack = go && ph >= 8'hbe;
    end
endmodule
`default_nettype wire

// File: rtl/csv_coarse_seek.sv
// Coarse seek velocity control: tracks-to-go, velocity codes, crossing pulse,
// region sequencing and seek status flags.
// Assumes detector inputs are asynchronous comparator outputs.
`timescale 1ns/10ps
`default_nettype none

module csv_coarse_seek #(
    parameter int TIMEOUT_CYC = 400000,
    parameter int PULSE_CYC   = csv_pkg::CYL_PULSE_CYC
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rstn,
    // Processor side
    input  wire csv_pkg::csv_req_s        req,
    input  wire logic                     speedCheckStart,
    output logic [csv_pkg::TMR_W-1:0]     speedCount,
    output logic [csv_pkg::CYL_W-1:0]     tracksToGo,
    output logic                          onTrack,
    output logic                          seekFault,
    output csv_pkg::csv_mode_e            mode,
    // Detector inputs
    input  wire logic                     posPeak,
    input  wire logic                     posPeakPlus,
    input  wire logic                     posPeakMinus,
    input  wire logic                     zeroCross,
    input  wire logic                     halfTrack,
    input  wire logic                     fineHold,
    input  wire logic                     forward,
    // Analog side
    output logic [csv_pkg::VEL_W-1:0]     dacCode,
    output logic [1:0]                    fillSel,
    output logic                          integClamp,
    output logic                          cylPulse,
    output logic                          posSlope,
    output csv_pkg::csv_vel_s             velCtl
);
    import csv_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] syncA;
    logic [NSYNC-1:0] syncB;
    logic             peakS, peakPS, peakMS, zeroS, halfS, holdS, fwdS;
    logic             holdD;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncA <= '0;
            syncB <= '0;
        end else begin
            syncA <= {posPeak, posPeakPlus, posPeakMinus, zeroCross, halfTrack, fineHold, forward};
            syncB <= syncA;
        end
    end
    assign {peakS, peakPS, peakMS, zeroS, halfS, holdS, fwdS} = syncB;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) holdD <= 1'b0;
        else       holdD <= holdS;
    end

    // ****************************************
    // Velocity table
    // ****************************************
    // Fill steps near the target, where the integrated velocity is small
    localparam logic [7:0] FILL3_BELOW = 8'h04;
    localparam logic [7:0] FILL2_BELOW = 8'h08;
    localparam logic [7:0] FILL1_BELOW = 8'h10;

    // Square-root profile, scaled so 255 tracks gives the top code.
    // Fill bits rise as the target nears, where the integrated velocity is small.
    function automatic logic [VEL_W-1:0] velLookup(input logic [CYL_W-1:0] t);
        logic [7:0] idx;
        logic [7:0] root;
        logic [1:0] fill;
        idx  = (t > CYL_W'(TBL_TOP)) ? 8'hff : t[7:0];
        root = 8'h00;
        for (int b = 3; b >= 0; b--) begin
            if ((({4'h0, root[3:0]} | (8'h01 << b)) * ({4'h0, root[3:0]} | (8'h01 << b)))
                <= {8'h00, idx})
                root[3:0] = root[3:0] | 4'(1 << b);
        end
        if (idx < FILL3_BELOW)      fill = 2'h3;
        else if (idx < FILL2_BELOW) fill = 2'h2;
        else if (idx < FILL1_BELOW) fill = 2'h1;
        else                  fill = 2'h0;
        velLookup = (t < FILL_LIMIT) ? {fill, root[3:0], 2'h0}
                                     : 8'({root[3:0], 4'h0} | {4'h0, root[3:0]});
    endfunction

    function automatic logic [CYL_W-1:0] absDiff(input logic [CYL_W-1:0] a,
                                                 input logic [CYL_W-1:0] b);
        absDiff = (a > b) ? CYL_W'(a - b) : CYL_W'(b - a);
    endfunction

    // ****************************************
    // Crossing pulse one-shot
    // ****************************************
    localparam int PW = $clog2(PULSE_CYC + 1);
    logic          armed;
    logic [PW-1:0] pulseCnt;
    logic          zeroD;
    logic          crossEdge;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) zeroD <= 1'b0;
        else       zeroD <= zeroS;
    end
    assign crossEdge = zeroS && !zeroD;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            armed    <= 1'b0;
            pulseCnt <= '0;
        end else if (peakS) begin
            armed <= 1'b1;
            if (pulseCnt != '0) pulseCnt <= pulseCnt - PW'(1);
        end else if (armed && crossEdge && pulseCnt == '0) begin
            armed    <= 1'b0;
            pulseCnt <= PW'(PULSE_CYC);
        end else if (pulseCnt != '0) begin
            pulseCnt <= pulseCnt - PW'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) cylPulse <= 1'b0;
        else       cylPulse <= (pulseCnt != '0);
    end

    // Falling edge of the pulse marks one finished crossing
    logic cylPulseD;
    logic crossDone;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) cylPulseD <= 1'b0;
        else       cylPulseD <= cylPulse;
    end
    assign crossDone = cylPulseD && !cylPulse;

    // Code waits one edge so the table sees the decremented count
    logic crossDoneD;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) crossDoneD <= 1'b0;
        else       crossDoneD <= crossDone;
    end

    // ****************************************
    // Seek sequencing
    // ****************************************
    logic               start;
    logic               seeking;
    logic [TMR_W+8-1:0] seekTimer;
    logic               timedOut;

    assign start    = (req.seek || req.home) && (mode != CSV_COARSE);
    assign seeking  = (mode == CSV_COARSE);
    assign timedOut = seeking && (seekTimer == (TMR_W+8)'(TIMEOUT_CYC));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode <= CSV_IDLE;
        end else begin
            case (mode)
                CSV_IDLE: begin
                    if (start) begin
                        mode <= CSV_COARSE;
                    end
                end
                CSV_COARSE: begin
                    if (timedOut) begin
                        mode <= CSV_IDLE;
                    end else if (tracksToGo == '0 && halfS) begin
                        mode <= CSV_SETTLE;
                    end
                end
                CSV_SETTLE: begin
                    if (start) begin
                        mode <= CSV_COARSE;
                    end
                end
                default: begin
                    mode <= CSV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)        seekTimer <= '0;
        else if (start)   seekTimer <= '0;
        else if (seeking) seekTimer <= seekTimer + (TMR_W+8)'(1);
    end

    // Home seek targets cylinder zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tracksToGo <= '0;
        end else if (start) begin
            tracksToGo <= req.home ? req.curCyl : absDiff(req.curCyl, req.dstCyl);
        end else if (seeking && crossDone && tracksToGo != '0) begin
            tracksToGo <= tracksToGo - CYL_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)      posSlope <= 1'b0;
        else if (start) posSlope <= req.home ? 1'b0 : (req.dstCyl > req.curCyl);
    end

    // Fault set wins over the next request's clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seekFault <= 1'b0;
        end else if (timedOut) begin
            seekFault <= 1'b1;
        end else if (start) begin
            seekFault <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            onTrack <= 1'b0;
        end else if (seeking && tracksToGo == '0 && halfS && !timedOut) begin
            onTrack <= 1'b1;
        end else if (start) begin
            onTrack <= 1'b0;
        end
    end

    // ****************************************
    // Spindle speed channel
    // ****************************************
    // Counts clocks between processor strobes; saturates rather than wraps.
    logic [TMR_W-1:0] speedRun;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            speedRun   <= '0;
            speedCount <= '0;
        end else if (speedCheckStart) begin
            speedCount <= speedRun;
            speedRun   <= '0;
        end else if (speedRun != '1) begin
            speedRun <= speedRun + TMR_W'(1);
        end
    end

    // ****************************************
    // Velocity code and integrator clamp
    // ****************************************
    logic [VEL_W-1:0] tblCode;
    assign tblCode = velLookup(tracksToGo);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dacCode <= '0;
            fillSel <= '0;
        end else if (start) begin
            dacCode <= '0;
            fillSel <= '0;
        end else if (seeking && (crossDoneD || seekTimer == '0)) begin
            if (tracksToGo < FILL_LIMIT) begin
                dacCode <= tblCode & FILL_MASK;
                fillSel <= tblCode[FILL_MSB:FILL_LSB];
            end else begin
                dacCode <= tblCode;
                fillSel <= '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) integClamp <= 1'b0;
        else       integClamp <= seeking && (tracksToGo < CLAMP_LIMIT) && (pulseCnt != '0);
    end

    // ****************************************
    // Region sequencing for velocity measurement
    // ****************************************
    logic peakLatch;
    logic inPeak;
    logic inPeakD;
    logic firstHalf;

    assign inPeak = peakPS || peakMS;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) inPeakD <= 1'b0;
        else       inPeakD <= inPeak;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            peakLatch <= 1'b0;
            firstHalf <= 1'b0;
        end else if (start) begin
            firstHalf <= 1'b1;
        end else if (holdS && !holdD && firstHalf) begin
            peakLatch <= req.preset;
        end else if (inPeak && !inPeakD) begin
            firstHalf <= 1'b0;
            peakLatch <= peakPS;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            velCtl <= '0;
        end else begin
            velCtl.regionA   <= !inPeak && peakLatch;
            velCtl.regionB   <= !inPeak && !peakLatch;
            velCtl.amplify   <= !inPeak;
            velCtl.integrate <= inPeak;
            velCtl.invertIn  <= peakLatch ^ fwdS;
        end
    end

endmodule

`default_nettype wire

// File: rtl/csv_pkg.sv
// Package for the coarse seek velocity control block.
// Assumes one 20 MHz clock domain; all analog parts sit outside.
package csv_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_MHZ          = 20;
    localparam int CYL_PULSE_NS     = 4000;
    localparam int CLK_PERIOD_NS    = 1000 / CLK_MHZ;
    localparam int CYL_PULSE_CYC    = (CYL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // Widths and thresholds
    // ****************************************
    localparam int CYL_W            = 16;
    localparam int VEL_W            = 8;
    localparam int TMR_W            = 16;
    localparam int TBL_TOP          = 255;
    localparam logic [CYL_W-1:0] FILL_LIMIT  = 16'h0010;
    localparam logic [CYL_W-1:0] CLAMP_LIMIT = 16'h0100;
    localparam int FILL_LSB         = 6;
    localparam int FILL_MSB         = 7;
    localparam logic [VEL_W-1:0] FILL_MASK   = 8'h3f;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        CSV_IDLE,
        CSV_COARSE,
        CSV_SETTLE
    } csv_mode_e;

    // Request from the control processor
    typedef struct packed {
        logic             seek;
        logic             home;
        logic [CYL_W-1:0] curCyl;
        logic [CYL_W-1:0] dstCyl;
        logic             preset;
    } csv_req_s;

    // Region controls toward the velocity generator
    typedef struct packed {
        logic regionA;
        logic regionB;
        logic amplify;
        logic integrate;
        logic invertIn;
    } csv_vel_s;

endpackage
